// ---- core/ctc_top.sv ----
// clock source selection, crystal start sequencing and trace pin routing
//
// The strobed register port is this design's own decision.
`timescale 1ns/100ps
`default_nettype none
module ctc_top #(
	parameter int PWRUP_US = 100,
	parameter int US_CNT_W = 16
) (
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic dbg_rst,
	input wire logic pwr_rst,
	input wire logic clk_en,
	input wire ctc_pkg::ctc_bus_s bus,
	output logic [31:0] bus_rdata,
	input wire logic fast_clock_start_task,
	input wire logic slow_clock_start_task,
	output logic fast_clock_started_event,
	output logic fast_crystal_oscillator,
	output logic [1:0] source_field,
	output logic slow_bypass,
	output logic slow_external,
	output logic slow_rc_ulp,
	output logic [6:0] calibration_interval,
	input wire ctc_pkg::ctc_trace_s trace_in,
	output ctc_pkg::ctc_trace_s trace_pin_o,
	output ctc_pkg::ctc_trace_s trace_pin_oe,
	output logic trace_clock_pin_o,
	output logic trace_clock_pin_oe,
	output logic irq
);
	typedef struct packed {
		logic [1:0] src;
		logic byp;
		logic ext;
		logic [7:0] deb;
		logic [6:0] cal;
		logic [1:0] spd;
		logic [1:0] mux;
		logic rc_ulp;
		logic [1:0] copy;
		ctc_pkg::ctc_fx_e st;
		logic [6:0] pre;
		logic [US_CNT_W-1:0] us;
		logic sts;
		logic msk;
		logic evt;
		logic [31:0] rdata;
		logic [7:0] tdiv;
		logic tclk;
		ctc_pkg::ctc_trace_s po;
		ctc_pkg::ctc_trace_s poe;
		logic tclk_oe;
	} ctc_state_s;

	ctc_state_s r;
	ctc_state_s nxt;
	logic us_tick;
	logic [US_CNT_W-1:0] pwrup_us;
	logic wr_src;

	assign pwrup_us = US_CNT_W'(PWRUP_US);
	assign us_tick = (r.pre == 7'(ctc_pkg::US_CYC - 1));
	assign wr_src = bus.wr && bus.addr == ctc_pkg::OFS_SRC;

	////////////////////////////////////////////////////////////////////////
	always_comb begin
		nxt = r;
		nxt.evt = 1'b0;
		nxt.rdata = 32'h0000_0000;
		// register writes
		if (bus.wr) begin
			unique case (bus.addr)
				ctc_pkg::OFS_SRC: begin
					nxt.src = bus.wdata[ctc_pkg::SRC_LSB +: 2];
					nxt.byp = bus.wdata[ctc_pkg::BYP_BIT];
					nxt.ext = bus.wdata[ctc_pkg::EXT_BIT];
				end
				// a write during start-up is the caller's fault; taken as is
				ctc_pkg::OFS_DEBOUNCE: nxt.deb = bus.wdata[7:0];
				ctc_pkg::OFS_CAL_IV: nxt.cal = bus.wdata[6:0];
				ctc_pkg::OFS_TRACE: begin
					nxt.spd = bus.wdata[ctc_pkg::SPD_LSB +: 2];
					nxt.mux = bus.wdata[ctc_pkg::MUX_LSB +: 2];
				end
				ctc_pkg::OFS_RC_MODE: nxt.rc_ulp = bus.wdata[0];
				ctc_pkg::OFS_IRQ_MSK: nxt.msk = bus.wdata[0];
				default: ;
			endcase
		end
		// register reads, answered one cycle later
		if (bus.rd) begin
			unique case (bus.addr)
				ctc_pkg::OFS_SRC_COPY: nxt.rdata[1:0] = r.copy;
				ctc_pkg::OFS_SRC: begin
					nxt.rdata[ctc_pkg::SRC_LSB +: 2] = r.src;
					nxt.rdata[ctc_pkg::BYP_BIT] = r.byp;
					nxt.rdata[ctc_pkg::EXT_BIT] = r.ext;
				end
				ctc_pkg::OFS_DEBOUNCE: nxt.rdata[7:0] = r.deb;
				ctc_pkg::OFS_CAL_IV: nxt.rdata[6:0] = r.cal;
				ctc_pkg::OFS_TRACE: begin
					nxt.rdata[ctc_pkg::SPD_LSB +: 2] = r.spd;
					nxt.rdata[ctc_pkg::MUX_LSB +: 2] = r.mux;
				end
				ctc_pkg::OFS_RC_MODE: nxt.rdata[0] = r.rc_ulp;
				ctc_pkg::OFS_IRQ_STS: nxt.rdata[0] = r.sts;
				ctc_pkg::OFS_IRQ_MSK: nxt.rdata[0] = r.msk;
				ctc_pkg::OFS_OSC_STATE: nxt.rdata[3:0] = r.st;
				default: ;
			endcase
		end
		if (slow_clock_start_task) begin
			nxt.copy = r.src;
		end
		// crystal start: power-up wait, then debounce wait, in microseconds
		nxt.pre = us_tick ? 7'h00 : 7'(r.pre + 7'h01);
		unique case (r.st)
			ctc_pkg::FX_IDLE: begin
				if (fast_clock_start_task) begin
					nxt.st = ctc_pkg::FX_PWRUP;
					nxt.us = '0;
					nxt.pre = 7'h00;
				end
			end
			ctc_pkg::FX_PWRUP: begin
				if (us_tick) begin
					nxt.us = US_CNT_W'(r.us + 1'b1);
					if (US_CNT_W'(r.us + 1'b1) >= pwrup_us) begin
						nxt.st = ctc_pkg::FX_DEBOUNCE;
						nxt.us = '0;
					end
				end
			end
			ctc_pkg::FX_DEBOUNCE: begin
				if (r.us >= US_CNT_W'(r.deb)) begin
					nxt.st = ctc_pkg::FX_RUN;
					nxt.evt = 1'b1;
				end else if (us_tick) begin
					nxt.us = US_CNT_W'(r.us + 1'b1);
				end
			end
			ctc_pkg::FX_RUN: ;
			default: nxt.st = ctc_pkg::FX_IDLE;
		endcase
		// sticky flag: the set wins over a write-one clear
		if (bus.wr && bus.addr == ctc_pkg::OFS_IRQ_STS && bus.wdata[0]) begin
			nxt.sts = 1'b0;
		end
		if (nxt.evt) begin
			nxt.sts = 1'b1;
		end
		// trace pin clock: half period follows the port speed
		if (r.tdiv >= 8'(ctc_pkg::half_cycles(r.spd) - 8'h01)) begin
			nxt.tdiv = 8'h00;
			nxt.tclk = ~r.tclk;
		end else begin
			nxt.tdiv = 8'(r.tdiv + 8'h01);
		end
		// pin routing; an unused code behaves as plain GPIO
		nxt.po = '0;
		nxt.poe = '0;
		nxt.tclk_oe = 1'b0;
		unique case (r.mux)
			ctc_pkg::MUX_SERIAL: begin
				nxt.po.serial_wire_trace_output = trace_in.serial_wire_trace_output;
				nxt.poe.serial_wire_trace_output = 1'b1;
			end
			ctc_pkg::MUX_PARALLEL: begin
				nxt.po.data = trace_in.data;
				nxt.poe.data = 4'hf;
				nxt.tclk_oe = 1'b1;
			end
			default: ;
		endcase
		// separate reset scopes keep retained registers alive
		if (sys_rst) begin
			nxt.src = ctc_pkg::SRC_RST;
			nxt.byp = 1'b0;
			nxt.ext = 1'b0;
			nxt.deb = ctc_pkg::DEB_RST;
			nxt.rc_ulp = 1'b0;
			nxt.copy = ctc_pkg::SRC_RST;
			nxt.st = ctc_pkg::FX_IDLE;
			nxt.pre = 7'h00;
			nxt.us = '0;
			nxt.sts = 1'b0;
			nxt.msk = 1'b0;
			nxt.evt = 1'b0;
			nxt.rdata = 32'h0000_0000;
			nxt.po = '0;
			nxt.poe = '0;
			nxt.tclk_oe = 1'b0;
		end
		if (dbg_rst) begin
			nxt.spd = ctc_pkg::TRC_RST;
			nxt.mux = ctc_pkg::TRC_RST;
			nxt.tdiv = 8'h00;
			nxt.tclk = 1'b0;
		end
		if (pwr_rst) begin
			nxt.cal = ctc_pkg::CAL_RST;
		end
	end

	// clock enable low freezes every flop, resets included
	always_ff @(posedge ref_clk) begin
		if (clk_en) begin
			r <= nxt;
		end
	end

	assign bus_rdata = r.rdata;
	assign fast_clock_started_event = r.evt;
	assign fast_crystal_oscillator = (r.st != ctc_pkg::FX_IDLE);
	assign source_field = r.src;
	assign slow_bypass = r.byp;
	assign slow_external = r.ext;
	assign slow_rc_ulp = r.rc_ulp;
	assign calibration_interval = r.cal;
	assign trace_pin_o = r.po;
	assign trace_pin_oe = r.poe;
	assign trace_clock_pin_o = r.tclk;
	assign trace_clock_pin_oe = r.tclk_oe;
	assign irq = r.sts & r.msk;

	////////////////////////////////////////////////////////////////////////
	// checks
	// counter frozen by clk_en like the state, else a stalled start looks long
	logic [US_CNT_W+7:0] start_cyc;
	always_ff @(posedge ref_clk) begin
		if (clk_en) begin
			if (sys_rst || r.st == ctc_pkg::FX_IDLE) begin
				start_cyc <= '0;
			end else begin
				start_cyc <= (US_CNT_W+8)'(start_cyc + 1'b1);
			end
		end
	end

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (sys_rst);

	sequence src_write;
		clk_en && wr_src && !sys_rst;
	endsequence
	sequence idle_start;
		clk_en && r.st == ctc_pkg::FX_IDLE && fast_clock_start_task;
	endsequence
	sequence run_start;
		clk_en && r.st == ctc_pkg::FX_RUN && fast_clock_start_task;
	endsequence
	sequence route_gpio;
		clk_en && r.mux == ctc_pkg::MUX_GPIO;
	endsequence
	sequence route_serial;
		clk_en && r.mux == ctc_pkg::MUX_SERIAL;
	endsequence
	sequence route_par;
		clk_en && r.mux == ctc_pkg::MUX_PARALLEL;
	endsequence

	AST_SRC_FIELD: assert property (src_write |=> source_field == $past(bus.wdata[1:0]))
		else $error("source field not taken from write");
	AST_BYPASS: assert property (src_write |=> slow_bypass == $past(bus.wdata[16]))
		else $error("bypass bit not taken from write");
	AST_EXTERNAL: assert property (src_write |=> slow_external == $past(bus.wdata[17]))
		else $error("external bit not taken from write");
	AST_START: assert property (idle_start |=>
		fast_crystal_oscillator && !fast_clock_started_event)
		else $error("crystal did not start on task");
	AST_START_IGNORED: assert property (run_start |=> r.st == ctc_pkg::FX_RUN)
		else $error("start task taken outside idle");
	AST_OSC_RESET: assert property (disable iff (1'b0)
		clk_en && sys_rst |=> !fast_crystal_oscillator)
		else $error("crystal still on after reset");
	// power-up and debounce both counted, debounce is static during start
	AST_EVENT_LATE: assert property (fast_clock_started_event |->
		start_cyc >= (US_CNT_W+8)'((PWRUP_US + int'(r.deb)) * ctc_pkg::US_CYC))
		else $error("started event before power-up and debounce time");
	AST_EVENT_PULSE: assert property (fast_clock_started_event |=>
		!fast_clock_started_event)
		else $error("started event longer than one cycle");
	AST_EVENT_STICKY: assert property (fast_clock_started_event |-> r.sts)
		else $error("started event did not set status");
	AST_CAL_KEEP: assert property (disable iff (1'b0)
		clk_en && sys_rst && !pwr_rst |=> $stable(calibration_interval))
		else $error("retained interval lost on reset");
	AST_CAL_PWR: assert property (disable iff (1'b0)
		clk_en && pwr_rst |=> calibration_interval == ctc_pkg::CAL_RST)
		else $error("interval not cleared by power reset");
	AST_TRACE_KEEP: assert property (disable iff (1'b0)
		clk_en && sys_rst && !dbg_rst && !bus.wr |=>
		r.mux == $past(r.mux) && r.spd == $past(r.spd))
		else $error("trace config lost on reset");
	AST_TRACE_DBG: assert property (disable iff (1'b0)
		clk_en && dbg_rst |=> r.mux == ctc_pkg::TRC_RST && r.spd == ctc_pkg::TRC_RST)
		else $error("trace config not cleared by debug reset");
	AST_TCLK_HALF: assert property (clk_en && r.spd == 2'h0 && !dbg_rst && $changed(r.tclk) |=>
		!$changed(r.tclk))
		else $error("trace clock toggles too fast");
	AST_MUX_GPIO: assert property (route_gpio |=> trace_pin_oe == '0 && !trace_clock_pin_oe)
		else $error("trace pin driven in gpio mode");
	AST_MUX_SERIAL: assert property (route_serial |=>
		trace_pin_oe.serial_wire_trace_output && trace_pin_oe.data == 4'h0 && !trace_clock_pin_oe)
		else $error("serial routing wrong");
	AST_SWO_DATA: assert property (route_serial |=> trace_pin_o.serial_wire_trace_output == $past(trace_in.serial_wire_trace_output))
		else $error("serial trace value not routed");
	AST_MUX_PAR: assert property (route_par |=>
		trace_clock_pin_oe && trace_pin_oe.data == 4'hf)
		else $error("parallel routing wrong");
	AST_PAR_DATA: assert property (route_par |=> trace_pin_o.data == $past(trace_in.data))
		else $error("parallel trace data not routed");
	AST_COPY: assert property (clk_en && slow_clock_start_task |=> r.copy == $past(r.src))
		else $error("source copy not captured");
	AST_COPY_HOLD: assert property (clk_en && !slow_clock_start_task |=>
		r.copy == $past(r.copy))
		else $error("source copy changed without task");
endmodule
`default_nettype wire

// ---- core/ctc_pkg.sv ----
// constants and types of the clock source and trace configuration block
// What this block does
// - two-bit field selects slow clock source
// - bypass bit picks rail-to-rail external clock
// - external bit takes external source instead crystal
// - fast start task starts crystal oscillator
// - started event after power-up plus debounce
// - calibration interval survives ordinary reset
// - trace config reset only by debug reset
// - speed field picks 32/16/8/4 MHz trace clock
// - trace clock pin outputs port clock halved
// - routing zero leaves all pins as GPIO
// - routing one routes serial trace only
// - routing two routes clock and parallel data
// - slow start task captures source into copy
`default_nettype none
package ctc_pkg;
	localparam logic [11:0] OFS_SRC_COPY = 12'h41c;
	localparam logic [11:0] OFS_SRC = 12'h518;
	localparam logic [11:0] OFS_DEBOUNCE = 12'h528;
	localparam logic [11:0] OFS_CAL_IV = 12'h538;
	localparam logic [11:0] OFS_TRACE = 12'h55c;
	localparam logic [11:0] OFS_RC_MODE = 12'h5b4;
	localparam logic [11:0] OFS_IRQ_STS = 12'h600;
	localparam logic [11:0] OFS_IRQ_MSK = 12'h604;
	localparam logic [11:0] OFS_OSC_STATE = 12'h608;
	// field positions
	localparam int SRC_LSB = 0;
	localparam int BYP_BIT = 16;
	localparam int EXT_BIT = 17;
	localparam int SPD_LSB = 0;
	localparam int MUX_LSB = 16;
	localparam logic [1:0] SRC_RC = 2'h0;
	localparam logic [1:0] SRC_XTAL = 2'h1;
	localparam logic [1:0] SRC_SYNTH = 2'h2;
	localparam logic [1:0] MUX_GPIO = 2'h0;
	localparam logic [1:0] MUX_SERIAL = 2'h1;
	localparam logic [1:0] MUX_PARALLEL = 2'h2;
	// reset values
	localparam logic [1:0] SRC_RST = 2'h0;
	localparam logic [7:0] DEB_RST = 8'h10;
	localparam logic [6:0] CAL_RST = 7'h00;
	localparam logic [1:0] TRC_RST = 2'h0;
	// timing
	localparam int CLK_KHZ = 100000;
	localparam int US_NS = 1000;
	localparam int CLK_NS = 10;
	localparam int US_CYC = US_NS / CLK_NS;
	localparam int TRC_MAX_KHZ = 32000;

	typedef enum logic [3:0] {
		FX_IDLE = 4'b0001,
		FX_PWRUP = 4'b0010,
		FX_DEBOUNCE = 4'b0100,
		FX_RUN = 4'b1000
	} ctc_fx_e;

	typedef struct packed {
		logic [11:0] addr;
		logic [31:0] wdata;
		logic wr;
		logic rd;
	} ctc_bus_s;

	typedef struct packed {
		logic serial_wire_trace_output;
		logic [3:0] data;
	} ctc_trace_s;

	// half period of the trace pin clock in ref clock cycles, at least one
	function automatic logic [7:0] half_cycles(input logic [1:0] spd);
		int c;
		c = CLK_KHZ / (TRC_MAX_KHZ >> spd);
		if (c < 1) begin
			c = 1;
		end
		return c[7:0];
	endfunction
endpackage
`default_nettype wire

// ---- test/ctc_top_tb.sv ----
// self-checking bench for the clock source and trace configuration block
`timescale 1ns/100ps
`default_nettype none
module ctc_top_tb;
	logic ref_clk, sys_rst, dbg_rst, pwr_rst, clk_en, fst, sst;
	ctc_pkg::ctc_bus_s bus;
	ctc_pkg::ctc_trace_s tin, tpo, tpoe;
	logic [31:0] bus_rdata, seed, rd_v;
	logic ev, osc, byp, ext, ulp, irq, tco, tcoe;
	logic [1:0] src;
	logic [6:0] civ;
	int n_mismatch, total_checks, cyc, model[int];

	ctc_top #(.PWRUP_US(2), .US_CNT_W(16)) dut (.ref_clk(ref_clk), .sys_rst(sys_rst),
		.dbg_rst(dbg_rst), .pwr_rst(pwr_rst), .clk_en(clk_en), .bus(bus),
		.bus_rdata(bus_rdata), .fast_clock_start_task(fst), .slow_clock_start_task(sst),
		.fast_clock_started_event(ev), .fast_crystal_oscillator(osc), .source_field(src),
		.slow_bypass(byp), .slow_external(ext), .slow_rc_ulp(ulp),
		.calibration_interval(civ), .trace_in(tin), .trace_pin_o(tpo), .trace_pin_oe(tpoe),
		.trace_clock_pin_o(tco), .trace_clock_pin_oe(tcoe), .irq(irq));

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end

	// hang guard, well above the longest start sequence
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 20000) begin
			n_mismatch++;
			stop_test();
		end
	end

	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic stop_test();
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		@(posedge ref_clk) bus <= '{a, d, 1'b1, 1'b0};
		@(posedge ref_clk) bus <= '{a, d, 1'b0, 1'b0};
		model[a] = d;
	endtask

	// read data stands only in the cycle after the strobe
	task automatic rd(input logic [11:0] a);
		@(posedge ref_clk) bus <= '{a, 32'h0, 1'b0, 1'b1};
		@(posedge ref_clk) bus <= '{a, 32'h0, 1'b0, 1'b0};
		#1 rd_v = bus_rdata;
	endtask

	// one-cycle pulse on {fast start, slow start, sys, dbg, pwr reset}
	task automatic pulse(input logic [4:0] m);
		@(posedge ref_clk) {fst, sst, sys_rst, dbg_rst, pwr_rst} <= m;
		@(posedge ref_clk) {fst, sst, sys_rst, dbg_rst, pwr_rst} <= 5'h00;
	endtask

	task automatic half(output int n);
		logic v;
		int k;
		k = 0;
		@(posedge ref_clk) #1 v = tco;
		while (tco === v && k < 200) begin
			@(posedge ref_clk) #1 k++;
		end
		v = tco;
		n = 0;
		while (tco === v && n < 200) begin
			@(posedge ref_clk) #1 n++;
		end
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		int n, d;
		logic [31:0] w;
		seed = 32'h2387;
		{sys_rst, dbg_rst, pwr_rst, clk_en, fst, sst} = 6'h3c;
		bus = '0;
		tin = '0;
		repeat (12) @(posedge ref_clk);
		{sys_rst, dbg_rst, pwr_rst} <= 3'h0;
		w = rnd();
		tin <= w[4:0];
		rd(ctc_pkg::OFS_SRC); chk("src_reset", rd_v, 32'h0);
		rd(ctc_pkg::OFS_TRACE); chk("trace_reset", rd_v, 32'h0);
		rd(ctc_pkg::OFS_DEBOUNCE); chk("deb_reset", rd_v, 32'h10);
		rd(12'h7fc); chk("unmapped", rd_v, 32'h0);
		$display("test reset done");
		// every source code with random bypass and external bits
		for (int s = 0; s < 3; s++) begin
			// external source only together with the crystal code
			w = (rnd() & ((s == 1) ? 32'h30000 : 32'h10000)) | s;
			wr(ctc_pkg::OFS_SRC, w);
			rd(ctc_pkg::OFS_SRC); chk("src_reg", rd_v, model[ctc_pkg::OFS_SRC]);
			chk("src_pins", {byp, ext, src}, {w[16], w[17], w[1:0]});
			pulse(5'h08);
			rd(ctc_pkg::OFS_SRC_COPY); chk("src_copy", rd_v, s);
		end
		wr(ctc_pkg::OFS_RC_MODE, 32'h1);
		rd(ctc_pkg::OFS_RC_MODE); chk("rc_mode", rd_v, 32'h1);
		chk("ulp_pin", ulp, 1'b1);
		$display("test source done");
		// routing and trace clock rate for every speed
		for (int m = 0; m < 3; m++) begin
			for (int s = 0; s < 4; s++) begin
				wr(ctc_pkg::OFS_TRACE, (m << 16) | s);
				rd(ctc_pkg::OFS_TRACE); chk("trace_reg", rd_v, (m << 16) | s);
				if (m == 2) begin
					half(n);
					half(n);
					chk("trc_half", n, 100000 / (32000 >> s));
				end
			end
			chk("clk_oe", tcoe, m == 2);
			chk("data_oe", tpoe.data, (m == 2) ? 4'hf : 4'h0);
			if (m < 2) begin
				chk("swo_oe", tpoe.serial_wire_trace_output, m == 1);
				chk("swo_o", tpo.serial_wire_trace_output, (m == 1) ? tin.serial_wire_trace_output : 1'b0);
			end else begin
				chk("data_o", tpo.data, tin.data);
			end
		end
		$display("test trace done");
		// start sequence: 2 us power-up then 1 us debounce
		wr(ctc_pkg::OFS_DEBOUNCE, 32'h1);
		pulse(5'h10);
		#1 chk("osc_on", osc, 1'b1);
		d = 1;
		while (ev !== 1'b1 && d < 1000) begin
			@(posedge ref_clk) #1 d++;
		end
		chk("start_lo", d >= 300, 1'b1);
		chk("start_hi", d <= 402, 1'b1);
		chk("irq_masked", irq, 1'b0);
		rd(ctc_pkg::OFS_IRQ_STS); chk("sts_set", rd_v, 32'h1);
		rd(ctc_pkg::OFS_OSC_STATE); chk("run_state", rd_v, 32'h8);
		wr(ctc_pkg::OFS_IRQ_MSK, 32'h1);
		#1 chk("irq_on", irq, 1'b1);
		wr(ctc_pkg::OFS_IRQ_STS, 32'h1);
		#1 chk("irq_off", irq, 1'b0);
		$display("test start done");
		// retention over ordinary and debug resets
		wr(ctc_pkg::OFS_CAL_IV, 32'h5a);
		wr(ctc_pkg::OFS_TRACE, 32'h10003);
		// a write while the clock enable is low must leave no trace
		clk_en <= 1'b0;
		wr(ctc_pkg::OFS_CAL_IV, 32'h33);
		clk_en <= 1'b1;
		rd(ctc_pkg::OFS_CAL_IV); chk("civ_frozen", rd_v, 32'h5a);
		pulse(5'h04);
		#1 chk("osc_rst", osc, 1'b0);
		chk("ulp_rst", ulp, 1'b0);
		rd(ctc_pkg::OFS_CAL_IV); chk("civ_keep", rd_v, 32'h5a);
		rd(ctc_pkg::OFS_TRACE); chk("trc_keep", rd_v, 32'h10003);
		pulse(5'h02);
		rd(ctc_pkg::OFS_TRACE); chk("trc_dbg", rd_v, 32'h0);
		chk("civ_pin", civ, 7'h5a);
		pulse(5'h01);
		#1 chk("civ_pwr", civ, 7'h0);
		$display("test retention done");
		stop_test();
	end
endmodule
`default_nettype wire
